// file: rtl/apf_page_bank.v
/*
  Paged advanced-feature register bank (page 0) with its indirect access
  window, plus the configuration-driven step event qualification.
  Assumes the host register interface presents one-cycle reg_wr / reg_rd
  strobes with an 8-bit address and data on ref_clk, and that step and
  classifier signals come from same-clock engine logic.
*/
// Overview of operation
// [RULE_01] Page 0 mapped only when page select zero
// [RULE_02] Bank loaded on enable; locked while disabled
// [RULE_03] Host writes: access, write mode, page, address, value
// [RULE_04] Read mode plus address returns addressed byte
// [RULE_05] Host sets modes once, clears at end
// [RULE_06] Page address advances after each value access
// [RULE_07] 16-bit long counter limit from byte pair
// [RULE_08] Host keeps program count at most eight
// [RULE_09] Host keeps program base above first address
// [RULE_10] Carry option: step interrupt only on overflow
// [RULE_11] False step filter needs classifier enabled
// [RULE_12] Count increments after debounce steps; default ten
// [RULE_13] Delta period is 16 bits, 2.56 ms units
// [RULE_14] Gain pair is sign, exponent, fraction
// [RULE_15] Gain also feeds state machine and classifier
// [RULE_16] Gain resets to temperature sensor value
// [RULE_17] Duration threshold is ODR times field over sixteen
// [RULE_18] Window count is field times sixteen
// [RULE_19] Host never writes reserved or calibration bytes
// [RULE_20] Calibration contents restored at every power-up
// [RULE_21] Host writes zero to unused option bits
// [RULE_22] Nonzero period holds increment flag low
// [RULE_23] Overflow flag set once count reaches 2^16
// [RULE_24] Value access without mode changes nothing
`timescale 1ns/100ps
`default_nettype none
`include "apf_regs.vh"

module apf_page_bank (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  input  wire        classifier_after_enable,
  input  wire        classifier_before_enable,
  input  wire        step_recognised,
  input  wire        step_overflow_event,
  input  wire [16:0] step_total,
  output wire [15:0] long_counter_limit,
  output wire [7:0]  program_total,
  output wire [15:0] program_base,
  output wire [15:0] step_window_period,
  output wire [31:0] step_window_period_us,
  output wire        false_step_filter,
  output wire        conversion_gain_sign,
  output wire [4:0]  conversion_gain_exp,
  output wire [9:0]  conversion_gain_frac,
  output wire [15:0] conversion_gain,
  output wire [3:0]  power_saving_duration,
  output wire [7:0]  power_saving_dur_x16,
  output wire [7:0]  power_saving_windows,
  output reg         step_count_inc,
  output reg         step_irq,
  output reg         step_increment_flag,
  output wire        step_overflow_flag,
  output wire        bank_ready
);

  ////////////////////////////////////////////////////////////////////////
  // Window control registers

  reg  [3:0] page_sel;           // Selected page
  reg  [7:0] page_addr;          // Auto-incrementing page address
  reg        page_read;          // Read mode
  reg        page_write;         // Write mode
  reg        extended_map_enable; // Host gate to the embedded map
  reg        onchip_processing_enable; // Embedded functions on
  reg        onchip_q;           // Enable one cycle ago, for load edge
  reg  [7:0] step_deb_cnt;       // Recognised steps since last count
  reg  [7:0] read_byte;          // Paged read mux

  wire [7:0]  bytes [0:11];      // Bank storage outputs
  wire [11:0] hit;               // One-hot offset decode
  wire        bank_load;         // Reload pulse on enable rising edge
  wire        value_wr;
  wire        value_rd;
  wire        paged_ok;
  integer     i;

  // Page 0 reachable only with gate, page zero and functions enabled
  assign paged_ok = extended_map_enable && (page_sel == `APF_PAGE_ZERO) // RULE_01
                    && onchip_processing_enable; // RULE_02
  assign bank_ready = paged_ok;
  assign value_wr = reg_wr && (reg_addr == `APF_PAGE_VALUE_ADDR);
  assign value_rd = reg_rd && (reg_addr == `APF_PAGE_VALUE_ADDR);
  // Contents reloaded when embedded functions switch on
  assign bank_load = onchip_processing_enable && !onchip_q; // RULE_02 RULE_20

  ////////////////////////////////////////////////////////////////////////
  // Main-map window registers

  // Host writes to the window and control registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      page_sel                 <= 4'h0;
      page_addr                <= 8'h00;
      page_read                <= 1'b0;
      page_write               <= 1'b0;
      extended_map_enable      <= 1'b0;
      onchip_processing_enable <= 1'b0;
      onchip_q                 <= 1'b0;
    end else begin
      onchip_q <= onchip_processing_enable;
      if (reg_wr) begin
        case (reg_addr)
          `APF_PAGE_SEL_ADDR: begin
            page_sel <= reg_wdata[`APF_PAGE_SEL_MSB:`APF_PAGE_SEL_LSB];
          end
          `APF_PAGE_ADDRESS_ADDR: begin
            page_addr <= reg_wdata;
          end
          `APF_PAGE_RW_ADDR: begin
            page_read  <= reg_wdata[`APF_PAGE_READ_BIT];
            page_write <= reg_wdata[`APF_PAGE_WRITE_BIT];
          end
          `APF_EXT_GATE_ADDR: begin
            extended_map_enable <= reg_wdata[`APF_EXT_ENABLE_BIT];
          end
          `APF_CONTROL_FOUR_ADDR: begin
            onchip_processing_enable <= reg_wdata[`APF_ONCHIP_EN_BIT];
          end
          default: begin
          end
        endcase
      end
      // Advance only on a moded value access; idle accesses leave it
      if (paged_ok && ((value_wr && page_write) || (value_rd && page_read))) begin
        page_addr <= page_addr + 8'h01; // RULE_06 RULE_24
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Page-0 storage

  assign hit[0]  = (page_addr == `APF_LC_LIMIT_L_ADDR);
  assign hit[1]  = (page_addr == `APF_LC_LIMIT_H_ADDR);
  assign hit[2]  = (page_addr == `APF_PROG_COUNT_ADDR);
  assign hit[3]  = (page_addr == `APF_PROG_BASE_L_ADDR);
  assign hit[4]  = (page_addr == `APF_PROG_BASE_H_ADDR);
  assign hit[5]  = (page_addr == `APF_STEP_OPT_ADDR);
  assign hit[6]  = (page_addr == `APF_STEP_DEB_ADDR);
  assign hit[7]  = (page_addr == `APF_STEP_WIN_L_ADDR);
  assign hit[8]  = (page_addr == `APF_STEP_WIN_H_ADDR);
  assign hit[9]  = (page_addr == `APF_GAIN_L_ADDR);
  assign hit[10] = (page_addr == `APF_GAIN_H_ADDR);
  assign hit[11] = (page_addr == `APF_POWER_TUNE_ADDR);

  // Store only in write mode on an open page; unmapped offsets ignored
  wire bank_wr = paged_ok && page_write && value_wr; // RULE_04 RULE_24

  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_lc_l (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[0]), .wr_data(reg_wdata), .value(bytes[0]));
  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_lc_h (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[1]), .wr_data(reg_wdata), .value(bytes[1]));
  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_prog_cnt (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[2]), .wr_data(reg_wdata), .value(bytes[2]));
  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_base_l (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[3]), .wr_data(reg_wdata), .value(bytes[3]));
  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_base_h (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[4]), .wr_data(reg_wdata), .value(bytes[4]));
  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_step_opt (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[5]), .wr_data(reg_wdata), .value(bytes[5]));
  apf_byte_reg #(.RST_VAL(`APF_STEP_DEB_RST)) u_step_deb ( // RULE_12
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[6]), .wr_data(reg_wdata), .value(bytes[6]));
  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_win_l (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[7]), .wr_data(reg_wdata), .value(bytes[7]));
  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_win_h (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[8]), .wr_data(reg_wdata), .value(bytes[8]));
  apf_byte_reg #(.RST_VAL(`APF_GAIN_L_RST)) u_gain_l ( // RULE_16
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[9]), .wr_data(reg_wdata), .value(bytes[9]));
  apf_byte_reg #(.RST_VAL(`APF_GAIN_H_RST)) u_gain_h ( // RULE_16
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[10]), .wr_data(reg_wdata), .value(bytes[10]));
  apf_byte_reg #(.RST_VAL(`APF_ZERO_RST)) u_power (
    .ref_clk(ref_clk), .nrst(nrst), .reload(bank_load),
    .wr_en(bank_wr && hit[11]), .wr_data(reg_wdata), .value(bytes[11]));

  ////////////////////////////////////////////////////////////////////////
  // Register readback

  // Paged byte select; unmapped offsets read zero
  always @* begin
    read_byte = 8'h00;
    for (i = 0; i < 12; i = i + 1) begin
      if (hit[i]) begin
        read_byte = bytes[i];
      end
    end
  end

  // Read data registered on the read strobe, one cycle latency
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `APF_PAGE_SEL_ADDR: begin
          reg_rdata <= {page_sel, 4'h0};
        end
        `APF_PAGE_ADDRESS_ADDR: begin
          reg_rdata <= page_addr;
        end
        `APF_PAGE_VALUE_ADDR: begin
          // Only a read-mode access on an open page returns bank data
          reg_rdata <= (paged_ok && page_read) ? read_byte : 8'h00; // RULE_04
        end
        `APF_PAGE_RW_ADDR: begin
          reg_rdata <= {1'b0, page_write, page_read, 5'h00};
        end
        `APF_EXT_GATE_ADDR: begin
          reg_rdata <= {extended_map_enable, 7'h00};
        end
        `APF_CONTROL_FOUR_ADDR: begin
          reg_rdata <= {3'h0, onchip_processing_enable, 4'h0};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded configuration

  assign long_counter_limit = {bytes[1], bytes[0]}; // RULE_07
  assign program_total      = bytes[2];
  assign program_base       = {bytes[4], bytes[3]};
  assign step_window_period = {bytes[8], bytes[7]}; // RULE_13
  // Period in microseconds; 16 x 12 bits fits 32 with margin
  assign step_window_period_us = {16'h0000, step_window_period} *
                                 `APF_STEP_WIN_UNIT_US; // RULE_13
  // Filter bit is dead unless a classifier position is on
  assign false_step_filter = bytes[5][`APF_FALSE_STEP_BIT] &&
      (classifier_after_enable || classifier_before_enable); // RULE_11
  assign conversion_gain      = {bytes[10], bytes[9]}; // RULE_15
  assign conversion_gain_sign = conversion_gain[15]; // RULE_14
  assign conversion_gain_exp  = conversion_gain[14:10]; // RULE_14
  assign conversion_gain_frac = conversion_gain[9:0]; // RULE_14
  assign power_saving_duration = bytes[11][`APF_DUR_MSB:`APF_DUR_LSB];
  // Duration in sixteenths of one ODR period
  assign power_saving_dur_x16 = {4'h0, power_saving_duration}; // RULE_17
  assign power_saving_windows = {bytes[11][`APF_WIN_MSB:`APF_WIN_LSB], 4'h0}; // RULE_18
  assign step_overflow_flag = (step_total >= `APF_STEP_COUNT_LIMIT); // RULE_23

  ////////////////////////////////////////////////////////////////////////
  // Step qualification

  // Debounce recognised steps, then gate flag by period and interrupt by carry option
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      step_deb_cnt        <= 8'h00;
      step_count_inc      <= 1'b0;
      step_irq            <= 1'b0;
      step_increment_flag <= 1'b0;
    end else begin
      step_count_inc <= 1'b0;
      if (step_recognised) begin
        if (step_deb_cnt + 8'h01 >= bytes[6]) begin
          step_count_inc <= 1'b1; // RULE_12
          step_deb_cnt   <= 8'h00;
        end else begin
          step_deb_cnt <= step_deb_cnt + 8'h01;
        end
      end
      // A nonzero period keeps the increment flag low
      step_increment_flag <= step_count_inc &&
                             (step_window_period == 16'h0000); // RULE_22
      // Carry option suppresses the interrupt on ordinary increments
      if (bytes[5][`APF_CARRY_COUNT_BIT]) begin
        step_irq <= step_overflow_event; // RULE_10
      end else begin
        step_irq <= step_count_inc || step_overflow_event;
      end
    end
  end

endmodule

`default_nettype wire

// file: pkg/apf_regs.vh
/*
  Constants for the paged advanced-feature register bank: window
  registers of the main map, page-0 offsets, reset values, field positions
  and timing figures.
  Assumes it is included by bare name from the design files.
*/
`ifndef APF_REGS_VH
`define APF_REGS_VH

// Window registers in the main map
`define APF_PAGE_SEL_ADDR      8'h02
`define APF_PAGE_ADDRESS_ADDR  8'h08
`define APF_PAGE_VALUE_ADDR    8'h09
`define APF_CONTROL_FOUR_ADDR  8'h13
`define APF_PAGE_RW_ADDR       8'h17
`define APF_EXT_GATE_ADDR      8'h3f

// Field positions in the main map
`define APF_PAGE_SEL_MSB       7
`define APF_PAGE_SEL_LSB       4
`define APF_PAGE_ZERO          4'h0
`define APF_PAGE_READ_BIT      5
`define APF_PAGE_WRITE_BIT     6
`define APF_EXT_ENABLE_BIT     7
`define APF_ONCHIP_EN_BIT      4

// Page-0 register offsets
`define APF_LC_LIMIT_L_ADDR    8'h54
`define APF_LC_LIMIT_H_ADDR    8'h55
`define APF_PROG_COUNT_ADDR    8'h56
`define APF_PROG_BASE_L_ADDR   8'h58
`define APF_PROG_BASE_H_ADDR   8'h59
`define APF_STEP_OPT_ADDR      8'h5d
`define APF_STEP_DEB_ADDR      8'h5e
`define APF_STEP_WIN_L_ADDR    8'haa
`define APF_STEP_WIN_H_ADDR    8'hab
`define APF_GAIN_L_ADDR        8'hb6
`define APF_GAIN_H_ADDR        8'hb7
`define APF_POWER_TUNE_ADDR    8'hd2

// Reset values
`define APF_ZERO_RST           8'h00
`define APF_STEP_DEB_RST       8'h0a
`define APF_GAIN_L_RST         8'hd1
`define APF_GAIN_H_RST         8'h19

// Step option fields
`define APF_CARRY_COUNT_BIT    3
`define APF_FALSE_STEP_BIT     2
`define APF_STEP_OPT_MASK      8'h0c

// Power tuning fields
`define APF_DUR_MSB            7
`define APF_DUR_LSB            4
`define APF_WIN_MSB            3
`define APF_WIN_LSB            0

// Timing: delta-time period unit in microseconds
`define APF_STEP_WIN_UNIT_US   32'h0000_0a00
`define APF_STEP_COUNT_LIMIT   17'h1_0000

`endif

// file: rtl/apf_byte_reg.v
/*
  One 8-bit configuration byte of the page-0 bank with its reset value
  and a boot reload strobe that restores the calibrated value.
  Assumes write and reload strobes come from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module apf_byte_reg #(
  parameter [7:0] RST_VAL = 8'h00 // Power-up and boot value
) (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       reload,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  output reg  [7:0] value
);

  // Boot reload outranks a host write in the same cycle
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      value <= RST_VAL;
    end else if (reload) begin
      value <= RST_VAL;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end

endmodule

`default_nettype wire

// file: test/apf_props.sv
/*
  Port checker for the paged advanced-feature bank.
  Assumes it is bound to apf_page_bank and the bank header is on the path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "apf_regs.vh"
module apf_props (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic        classifier_after_enable,
  input wire logic        classifier_before_enable,
  input wire logic        step_recognised,
  input wire logic        step_overflow_event,
  input wire logic [16:0] step_total,
  input wire logic [15:0] step_window_period,
  input wire logic [31:0] step_window_period_us,
  input wire logic        false_step_filter,
  input wire logic        conversion_gain_sign,
  input wire logic [4:0]  conversion_gain_exp,
  input wire logic [9:0]  conversion_gain_frac,
  input wire logic [15:0] conversion_gain,
  input wire logic [3:0]  power_saving_duration,
  input wire logic [7:0]  power_saving_dur_x16,
  input wire logic [7:0]  power_saving_windows,
  input wire logic        step_count_inc,
  input wire logic        step_irq,
  input wire logic        step_increment_flag,
  input wire logic        step_overflow_flag,
  input wire logic        bank_ready
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  // Value read while the bank is not mapped
  sequence s_locked_read;
    reg_rd && (reg_addr == `APF_PAGE_VALUE_ADDR) && !bank_ready;
  endsequence
  // Count increase with no delta period programmed
  sequence s_free_inc;
    step_count_inc && (step_window_period == 16'h0000);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_LOCKED_READ: assert property (s_locked_read |=> reg_rdata == 8'h00)
    else $error("locked read returned data");
  AST_IRQ_CAUSE: assert property (step_irq |-> $past(step_count_inc || step_overflow_event))
    else $error("step irq without cause");
  AST_FLAG_PULSE: assert property (s_free_inc |=> step_increment_flag)
    else $error("increment flag missing");
  // Stable nonzero period excludes a flag launched before it was set
  AST_FLAG_HELD: assert property ((step_window_period != 16'h0000) && $stable(step_window_period)
    |-> !step_increment_flag)
    else $error("increment flag with period set");
  AST_INC_CAUSE: assert property (step_count_inc |-> $past(step_recognised))
    else $error("count increase without step");
  AST_FILTER_GATE: assert property (false_step_filter
    |-> (classifier_after_enable || classifier_before_enable))
    else $error("false step filter without classifier");
  AST_OVERFLOW: assert property (step_overflow_flag == (step_total >= 17'h1_0000))
    else $error("overflow flag wrong");
  AST_GAIN_FIELDS: assert property (conversion_gain
    == {conversion_gain_sign, conversion_gain_exp, conversion_gain_frac})
    else $error("gain fields misplaced");
  AST_PERIOD_US: assert property (step_window_period_us
    == step_window_period * 32'h0000_0a00)
    else $error("period scaling wrong");
  AST_DUR: assert property (power_saving_dur_x16 == {4'h0, power_saving_duration})
    else $error("duration wrong");
  AST_WIN: assert property (power_saving_windows[3:0] == 4'h0)
    else $error("window count not multiple of sixteen");
endmodule
`default_nettype wire

// file: test/apf_host.sv
/*
  Host model: drives the main-map strobe bus and the paged window.
  Assumes strobes are taken on the rising edge; it changes at falling edges.
*/
`timescale 1ns/100ps
`default_nettype none
module apf_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One write strobe; lines scrambled after release so stale values never help
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // One read strobe; data taken a full cycle later
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  // Gate, engine enable and mode first, then page zero
  task open_bank(input logic [7:0] mode);
    wr(8'h3f, 8'h80);
    wr(8'h13, 8'h10);
    wr(8'h17, mode);
    wr(8'h02, 8'h00);
  endtask
  // Mode cleared first, then the gate
  task close_bank;
    wr(8'h17, 8'h00);
    wr(8'h3f, 8'h00);
  endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
/*
  Self-checking bench for the paged bank; writes only documented offsets.
  Assumes apf_host and apf_props compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t %s", $time, m); end end
module tb_top;
  logic        ref_clk, nrst, reg_wr, reg_rd, cl_a, cl_b, st_rec, st_ovf, inc, irq, flg;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, ptot, durx, wins;
  logic [16:0] st_tot;
  logic [15:0] lcl, pbase, per, gain;
  logic [31:0] per_us;
  logic [3:0]  dur;
  logic        filt, ovf, rdy;
  int          failures, cmp_count, cyc, inc_n, irq_n, flg_n;
  // Reset image of the bank, 16-bit pairs low byte first
  logic [7:0]  ra[12] = '{8'h54, 8'h55, 8'h56, 8'h58, 8'h59, 8'h5d, 8'h5e, 8'haa,
                         8'hab, 8'hb6, 8'hb7, 8'hd2};
  logic [7:0]  rv[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00,
                         8'h00, 8'hd1, 8'h19, 8'h00};
  apf_host host_i (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  apf_page_bank apf_page_bank_i (.ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .classifier_after_enable(cl_a), .classifier_before_enable(cl_b),
    .step_recognised(st_rec), .step_overflow_event(st_ovf), .step_total(st_tot),
    .long_counter_limit(lcl), .program_total(ptot), .program_base(pbase),
    .step_window_period(per), .step_window_period_us(per_us), .false_step_filter(filt),
    .conversion_gain_sign(), .conversion_gain_exp(), .conversion_gain_frac(),
    .conversion_gain(gain), .power_saving_duration(dur), .power_saving_dur_x16(durx),
    .power_saving_windows(wins), .step_count_inc(inc), .step_irq(irq),
    .step_increment_flag(flg), .step_overflow_flag(ovf), .bank_ready(rdy));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Pulse tallies and the hang limit
  always @(posedge ref_clk) begin
    inc_n += inc;
    irq_n += irq;
    flg_n += flg;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up;
    end
  end
  task wrap_up;
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task pw(input logic [7:0] a, input logic [7:0] v);
    host_i.wr(8'h08, a);
    host_i.wr(8'h09, v);
  endtask
  // Raw steps spaced so each registered pulse is seen once
  task steps(input int n);
    inc_n = 0;
    irq_n = 0;
    flg_n = 0;
    repeat (n) begin
      @(negedge ref_clk) st_rec = 1'b1;
      @(negedge ref_clk) st_rec = 1'b0;
      repeat (3) @(negedge ref_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset_vals;
    for (int i = 0; i < 12; i++) begin
      host_i.wr(8'h08, ra[i]);
      host_i.rd(8'h09, d);
      `CHK(d, rv[i], "reset byte")
    end
    `CHK(gain, 16'h19d1, "gain reset")
  endtask
  task t_write_auto;
    pw(8'h54, 8'h34);
    host_i.wr(8'h09, 8'h12);
    host_i.wr(8'h09, 8'h08);
    pw(8'h58, 8'h9c);
    host_i.wr(8'h09, 8'h01);
    `CHK(lcl, 16'h1234, "limit pair")
    `CHK(ptot, 8'h08, "program count")
    `CHK(pbase, 16'h019c, "program base")
    host_i.wr(8'h08, 8'h55);
    host_i.rd(8'h09, d);
    host_i.rd(8'h09, d);
    `CHK(d, 8'h08, "auto read")
    pw(8'h5e, 8'h06);
    host_i.wr(8'h08, 8'h5e);
    host_i.wr(8'h17, 8'h00);
    host_i.wr(8'h09, 8'h55);
    // Single-direction modes: the other direction must neither act nor advance
    host_i.wr(8'h17, 8'h40);
    host_i.rd(8'h09, d);
    `CHK(d, 8'h00, "read in write mode")
    host_i.wr(8'h17, 8'h20);
    host_i.wr(8'h09, 8'h55);
    host_i.wr(8'h17, 8'h60);
    host_i.rd(8'h09, d);
    `CHK(d, 8'h06, "mode off access")
  endtask
  task t_page_other;
    host_i.wr(8'h02, 8'h10);
    host_i.wr(8'h08, 8'h5e);
    host_i.rd(8'h09, d);
    `CHK(d, 8'h00, "other page read")
    `CHK(rdy, 1'b0, "other page ready")
    host_i.wr(8'h02, 8'h00);
  endtask
  task t_power_filter;
    pw(8'hd2, 8'h35);
    `CHK(dur, 4'h3, "duration")
    `CHK(durx, 8'h03, "duration sixteenths")
    `CHK(wins, 8'h50, "windows")
    // Host reprograms the gain pair, sign bit set
    pw(8'hb6, 8'h00);
    host_i.wr(8'h09, 8'hbc);
    `CHK(gain, 16'hbc00, "gain write")
    pw(8'h5d, 8'h04);
    `CHK(filt, 1'b0, "filter no classifier")
    cl_a = 1'b1;
    @(negedge ref_clk) `CHK(filt, 1'b1, "filter after")
    cl_a = 1'b0;
    cl_b = 1'b1;
    @(negedge ref_clk) `CHK(filt, 1'b1, "filter before")
  endtask
  task t_steps;
    pw(8'h5d, 8'h00);
    pw(8'h5e, 8'h02);
    steps(4);
    `CHK(inc_n, 2, "debounce")
    `CHK(flg_n, 2, "inc flag")
    `CHK(irq_n, 2, "step irq")
    pw(8'h5d, 8'h08);
    steps(4);
    `CHK(irq_n, 0, "carry irq")
    @(negedge ref_clk) st_ovf = 1'b1;
    @(negedge ref_clk) st_ovf = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(irq_n, 1, "overflow irq")
    pw(8'haa, 8'h01);
    `CHK(per_us, 32'h0000_0a00, "period us")
    steps(2);
    `CHK(flg_n, 0, "flag held")
    st_tot = 17'h0_ffff;
    @(negedge ref_clk) `CHK(ovf, 1'b0, "below overflow")
    st_tot = 17'h1_0000;
    @(negedge ref_clk) `CHK(ovf, 1'b1, "overflow")
  endtask
  task t_reload;
    host_i.close_bank;
    host_i.wr(8'h13, 8'h00);
    // Gate open again so only the disabled engine keeps the bank shut
    host_i.wr(8'h3f, 8'h80);
    host_i.wr(8'h17, 8'h60);
    host_i.wr(8'h08, 8'h5e);
    host_i.rd(8'h09, d);
    `CHK(d, 8'h00, "disabled read")
    `CHK(rdy, 1'b0, "disabled ready")
    host_i.open_bank(8'h60);
    host_i.wr(8'h08, 8'h5e);
    host_i.rd(8'h09, d);
    `CHK(d, 8'h0a, "reload")
    `CHK(gain, 16'h19d1, "gain reload")
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, cl_a, cl_b, st_rec, st_ovf} = 5'h00;
    st_tot = 17'h0_0000;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk) nrst = 1'b1;
    host_i.open_bank(8'h60);
    t_reset_vals;
    t_write_auto;
    t_page_other;
    t_power_filter;
    t_steps;
    t_reload;
    wrap_up;
  end
endmodule
bind apf_page_bank apf_props apf_props_i (.ref_clk, .nrst, .reg_rd, .reg_addr, .reg_rdata,
  .classifier_after_enable, .classifier_before_enable, .step_recognised,
  .step_overflow_event, .step_total, .step_window_period, .step_window_period_us,
  .false_step_filter, .conversion_gain_sign, .conversion_gain_exp, .conversion_gain_frac,
  .conversion_gain, .power_saving_duration, .power_saving_dur_x16, .power_saving_windows,
  .step_count_inc, .step_irq, .step_increment_flag, .step_overflow_flag, .bank_ready);
`default_nettype wire
